// file: src/charge_time_regs.vh
// register offsets, field positions and reset values for the charge time unit
`ifndef CHARGE_TIME_REGS_VH
`define CHARGE_TIME_REGS_VH
`define REF_CTRL_ADDR      12'h000
`define TIME_CTRL_ADDR     12'h004
`define CURR_CTRL_ADDR     12'h008
`define STATUS_ADDR        12'h00c
`define REF_CTRL_RESET     16'h0000
`define TIME_CTRL_RESET    16'h0000
`define CURR_CTRL_RESET    16'h0000
`define REF_CTRL_MASK      16'h00ff
`define TIME_CTRL_MASK     16'hbfff
`define CURR_CTRL_MASK     16'hff00
`define REF_ENABLE_BIT     7
`define REF_OUT_EN_BIT     6
`define REF_RANGE_BIT      5
`define REF_SUPPLY_BIT     4
`define UNIT_ENABLE_BIT    15
`define IDLE_STOP_BIT      13
`define DELAY_GEN_BIT      12
`define EDGE_GATE_BIT      11
`define EDGE_ORDER_BIT     10
`define CURR_GROUND_BIT    9
`define TRIG_OUT_BIT       8
`define EDGE_TWO_POL_BIT   7
`define EDGE_TWO_SRC_HI    6
`define EDGE_TWO_SRC_LO    5
`define EDGE_ONE_POL_BIT   4
`define EDGE_ONE_SRC_HI    3
`define EDGE_ONE_SRC_LO    2
`define EDGE_TWO_FLAG_BIT  1
`define EDGE_ONE_FLAG_BIT  0
`define CURR_RANGE_HI      9
`define CURR_RANGE_LO      8
`define CURR_TRIM_HI       15
`define CURR_TRIM_LO       10
`define REF_LEVEL_HI       3
`define REF_LEVEL_LO       0
`define SRC_PIN_ONE        2'h3
`define SRC_PIN_TWO        2'h2
`define SRC_OCMP_ONE       2'h1
`define SRC_TIMER_ONE      2'h0
`endif

// file: src/charge_time_unit.v
// charge time unit control logic with reference control and apb registers
`include "charge_time_regs.vh"
module charge_time_unit (
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        idle_mode_i,
  input  wire        ext_edge_pin_one_i,
  input  wire        ext_edge_pin_two_i,
  input  wire        output_compare_one_i,
  input  wire        timer_one_i,
  input  wire        cmp_two_out_i,
  output reg         ref_enable_o,
  output reg         reference_output_en_o,
  output reg         ref_range_select_o,
  output reg         ref_supply_select_o,
  output reg  [3:0]  ref_level_code_o,
  output reg  [1:0]  current_range_o,
  output reg  [5:0]  current_trim_o,
  output reg         current_ground_o,
  output reg         current_on_o,
  output reg         cmp_two_b_route_o,
  output reg         measure_pulse_o,
  output reg         delay_pulse_out_o,
  output reg         trigger_o
);

  localparam ST_IDLE   = 3'b001;
  localparam ST_CHARGE = 3'b010;
  localparam ST_PULSE  = 3'b100;

  reg [15:0] ref_ctrl;
  reg [15:0] time_ctrl;
  reg [15:0] curr_ctrl;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg        cmp_q;

  // source multiplexer shared by both channels
  function src_pick;
    input [1:0] sel;
    input       pin_one;
    input       pin_two;
    input       ocmp;
    input       tmr;
    begin
      case (sel)
        `SRC_PIN_ONE:  src_pick = pin_one;
        `SRC_PIN_TWO:  src_pick = pin_two;
        `SRC_OCMP_ONE: src_pick = ocmp;
        default:       src_pick = tmr;
      endcase
    end
  endfunction

  wire [1:0] sel_one = time_ctrl[`EDGE_ONE_SRC_HI:`EDGE_ONE_SRC_LO];
  wire [1:0] sel_two = time_ctrl[`EDGE_TWO_SRC_HI:`EDGE_TWO_SRC_LO];
  wire src_one = src_pick(sel_one, ext_edge_pin_one_i, ext_edge_pin_two_i,
                          output_compare_one_i, timer_one_i);
  wire src_two = src_pick(sel_two, ext_edge_pin_one_i, ext_edge_pin_two_i,
                          output_compare_one_i, timer_one_i);

  // unit runs when enabled and not stopped by idle
  wire running = time_ctrl[`UNIT_ENABLE_BIT] &
                 ~(time_ctrl[`IDLE_STOP_BIT] & idle_mode_i);
  wire gate_open = running & time_ctrl[`EDGE_GATE_BIT];
  wire delay_mode = running & time_ctrl[`DELAY_GEN_BIT];

  // per channel edge detection, index 0 is edge one and 1 edge two
  wire [1:0] chan_src;
  wire [1:0] chan_pol;
  wire [1:0] chan_ev;
  assign chan_src = {src_two, src_one};
  assign chan_pol = {time_ctrl[`EDGE_TWO_POL_BIT],
                     time_ctrl[`EDGE_ONE_POL_BIT]};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      reg  last;
      wire rise;
      wire fall;
      // sample taken every cycle, even while gated, so reopening shows no false edge
      always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
          last <= 1'b0;
        else
          last <= chan_src[g];
      end
      // polarity bit set means rising edge counts
      assign rise = chan_src[g] & ~last;
      assign fall = ~chan_src[g] & last;
      assign chan_ev[g] = gate_open &
        (chan_pol[g] ? rise : fall);
    end
  endgenerate

  wire ev_one     = chan_ev[0];
  wire ev_two_raw = chan_ev[1];
  // ordering looks at the flag or a same-cycle edge one event
  wire ev_two = ev_two_raw & (~time_ctrl[`EDGE_ORDER_BIT] |
    time_ctrl[`EDGE_ONE_FLAG_BIT] | ev_one);

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_en = psel_i & ~penable_i & ~pwrite_i;

  // one-hot register select shared by writes, reads and errors
  function [3:0] reg_hit;
    input [11:0] addr;
    begin
      case (addr)
        `REF_CTRL_ADDR:  reg_hit = 4'h1;
        `TIME_CTRL_ADDR: reg_hit = 4'h2;
        `CURR_CTRL_ADDR: reg_hit = 4'h4;
        `STATUS_ADDR:    reg_hit = 4'h8;
        default:         reg_hit = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] hit     = reg_hit(paddr_i);
  wire       addr_ok = |hit;
  wire       wr_ref  = wr_en & hit[0];
  wire       wr_time = wr_en & hit[1];
  wire       wr_curr = wr_en & hit[2];

  // byte-lane merge of a write into a 16 bit register
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  strb;
    input [15:0] msk;
    begin
      merge = old;
      if (strb[0])
        merge[7:0] = wd[7:0];
      if (strb[1])
        merge[15:8] = wd[15:8];
      merge = merge & msk;
    end
  endfunction

  reg [15:0] next_time;
  always @* begin
    next_time = time_ctrl;
    if (wr_time)
      next_time = merge(time_ctrl, pwdata_i, pstrb_i, `TIME_CTRL_MASK);
    // hardware set wins over a software clear in the same cycle
    if (ev_one)
      next_time[`EDGE_ONE_FLAG_BIT] = 1'b1;
    if (ev_two)
      next_time[`EDGE_TWO_FLAG_BIT] = 1'b1;
  end

  // reference register, written only in the access cycle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_ctrl <= `REF_CTRL_RESET;
    end else if (wr_ref) begin
      ref_ctrl <= merge(ref_ctrl, pwdata_i, pstrb_i,
                        `REF_CTRL_MASK);
    end
  end

  // current register, written only in the access cycle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      curr_ctrl <= `CURR_CTRL_RESET;
    end else if (wr_curr) begin
      curr_ctrl <= merge(curr_ctrl, pwdata_i, pstrb_i,
                         `CURR_CTRL_MASK);
    end
  end

  // control register also takes the hardware flag updates
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      time_ctrl <= `TIME_CTRL_RESET;
    end else begin
      time_ctrl <= next_time;
    end
  end

  // comparator sampled once so the state machine sees one value
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= cmp_two_out_i;
    end
  end

  // read word for the selected register; unmapped places read zero
  function [31:0] read_word;
    input [3:0]  sel;
    input [15:0] rf;
    input [15:0] tc;
    input [15:0] cc;
    input [2:0]  st;
    begin
      read_word = 32'h00000000;
      if (sel[0])
        read_word = {16'h0000, rf};
      if (sel[1])
        read_word = {16'h0000, tc};
      if (sel[2])
        read_word = {16'h0000, cc};
      if (sel[3])
        read_word = {29'h00000000, st};
    end
  endfunction

  // no wait state: setup registers pready so the first access cycle answers
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
    end
  end

  // read data taken at setup so it stands through the access cycle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      prdata_o <= read_word(hit, ref_ctrl, time_ctrl, curr_ctrl, state);
    end
  end

  // delay generator: idle, charging capacitor, pulse until trip clears
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (delay_mode & ev_one)
          next_state = ST_CHARGE;
      end
      ST_CHARGE: begin
        if (~delay_mode)
          next_state = ST_IDLE;
        else if (cmp_q)
          next_state = ST_PULSE;
      end
      ST_PULSE: begin
        if (~delay_mode | ~cmp_q)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire range_on = curr_ctrl[`CURR_RANGE_HI:`CURR_RANGE_LO] != 2'h0;
  // measurement: source on between edge one and edge two events
  wire meas_on = running & ~time_ctrl[`DELAY_GEN_BIT] &
    time_ctrl[`EDGE_ONE_FLAG_BIT] & ~time_ctrl[`EDGE_TWO_FLAG_BIT];
  wire charging = next_state == ST_CHARGE;
  wire pulsing  = next_state == ST_PULSE;

  // reference controls are plain registered copies
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_enable_o          <= 1'b0;
      reference_output_en_o <= 1'b0;
      ref_range_select_o    <= 1'b0;
      ref_supply_select_o   <= 1'b0;
      ref_level_code_o      <= 4'h0;
    end else begin
      ref_enable_o          <= ref_ctrl[`REF_ENABLE_BIT];
      reference_output_en_o <= ref_ctrl[`REF_OUT_EN_BIT];
      ref_range_select_o    <= ref_ctrl[`REF_RANGE_BIT];
      ref_supply_select_o   <= ref_ctrl[`REF_SUPPLY_BIT];
      ref_level_code_o      <= ref_ctrl[`REF_LEVEL_HI:`REF_LEVEL_LO];
    end
  end

  // current range and trim copies for the analog source
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      current_range_o <= 2'h0;
      current_trim_o  <= 6'h00;
    end else begin
      current_range_o <= curr_ctrl[`CURR_RANGE_HI:`CURR_RANGE_LO];
      current_trim_o  <= curr_ctrl[`CURR_TRIM_HI:`CURR_TRIM_LO];
    end
  end

  // ground overrides charging so a grounded source never ramps
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      current_ground_o <= 1'b0;
      current_on_o     <= 1'b0;
    end else begin
      current_ground_o <= time_ctrl[`CURR_GROUND_BIT];
      current_on_o     <= range_on & ~time_ctrl[`CURR_GROUND_BIT] &
        (meas_on | charging);
    end
  end

  // comparator b input follows the delay mode
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_two_b_route_o <= 1'b0;
    end else begin
      cmp_two_b_route_o <= delay_mode;
    end
  end

  // outputs registered per house style; a fully unclocked pulse path
  // would need an asynchronous cell outside this block
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      measure_pulse_o   <= 1'b0;
      delay_pulse_out_o <= 1'b0;
    end else begin
      measure_pulse_o   <= meas_on;
      delay_pulse_out_o <= pulsing;
    end
  end

  // trigger follows whichever pulse is active
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trigger_o <= 1'b0;
    end else begin
      trigger_o <= running & time_ctrl[`TRIG_OUT_BIT] &
        (meas_on | pulsing);
    end
  end

endmodule // charge_time_unit

// file: test/charge_time_unit_asserts.sv
// port checker for the charge time unit
module charge_time_unit_asserts (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cmp_two_out_i,
  input wire logic        current_ground_o,
  input wire logic [1:0]  current_range_o,
  input wire logic        delay_pulse_out_o,
  input wire logic        measure_pulse_o,
  input wire logic        trigger_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire wr = psel_i && penable_i && pready_o && pwrite_i;
  wire wt = wr && paddr_i == 12'h004;
  wire wc = wr && paddr_i == 12'h008;
  wire dp = measure_pulse_o || delay_pulse_out_o;
  property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("setup not answered");
  property p_err; pslverr_o |-> pready_o && paddr_i > 12'h00c; endproperty
  a_err: assert property (p_err) else $error("error on mapped place");
  property p_gnd; $changed(current_ground_o) |-> $past(wt) || $past(wt, 2);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground moved alone");
  property p_rng; $changed(current_range_o) |-> $past(wc) || $past(wc, 2);
  endproperty
  a_rng: assert property (p_rng) else $error("range moved alone");
  property p_dup; $rose(delay_pulse_out_o) |->
    $past(cmp_two_out_i) || $past(cmp_two_out_i, 2); endproperty
  a_dup: assert property (p_dup) else $error("pulse without trip");
  property p_ddn; !cmp_two_out_i [*3] |-> !delay_pulse_out_o; endproperty
  a_ddn: assert property (p_ddn) else $error("pulse outlives trip");
  property p_trg; trigger_o |-> dp || $past(dp); endproperty
  a_trg: assert property (p_trg) else $error("trigger without pulse");
  property p_mea; measure_pulse_o |-> !delay_pulse_out_o; endproperty
  a_mea: assert property (p_mea) else $error("both pulses high");
  cover property ($rose(delay_pulse_out_o));
  cover property ($rose(measure_pulse_o));
  cover property (pslverr_o);
endmodule // charge_time_unit_asserts

bind charge_time_unit charge_time_unit_asserts u_charge_time_unit_asserts (
  .ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pready_o, .pslverr_o, .cmp_two_out_i, .current_ground_o,
  .current_range_o, .delay_pulse_out_o, .measure_pulse_o, .trigger_o);

// file: test/edge_source_model.sv
// edge source lines and comparator two on the delay capacitor
module edge_source_model #(parameter logic [7:0] TRIP = 8'h14) (
  input  wire logic       ref_clk_i,
  input  wire logic       current_on_i,
  input  wire logic       current_ground_i,
  output logic      [3:0] line_o,
  output logic            cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cap = 8'h00;
  initial line_o = 4'h0;
  // saturating ramp: a stuck source must not wrap and fake a new trip
  always @(posedge ref_clk_i) begin
    if (current_ground_i)
      cap <= 8'h00;
    else if (current_on_i && cap != 8'hff)
      cap <= cap + 8'h01;
  end
  assign cmp_o = cap >= TRIP;
  task automatic set(input int i, input logic v);
    line_o[i] <= v;
  endtask
endmodule // edge_source_model

// file: test/charge_time_unit_tb.sv
// self-checking bench for the charge time unit
`define CHK(n, e, s) \
  n_tests++; \
  if ((s) !== (e)) begin \
    err_total++; \
    $display("unexpected %s exp %h got %h", n, e, s); \
  end
module charge_time_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, idle_mode_i = 1'b0, pready_o, pslverr_o, cmp, on, gnd;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, seed = 32'h35, prdata_o, r, cfg, f;
  logic [3:0] line;
  wire [7:0] refo;
  wire [5:0] ctrim;
  wire [1:0] crng;
  wire route, mpo, dpo, trg;
  logic [32:0] exp_q[$], ex;
  logic [16:0] t[5] = '{17'h0081c, 17'h0801c, 17'h1a81c, 17'h0a81c, 17'h1881c};
  int err_total = 0, n_tests = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  charge_time_unit u_charge_time_unit (
    .ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o,
    .idle_mode_i, .ext_edge_pin_one_i(line[3]), .ext_edge_pin_two_i(line[2]),
    .output_compare_one_i(line[1]), .timer_one_i(line[0]),
    .cmp_two_out_i(cmp), .ref_enable_o(refo[7]),
    .reference_output_en_o(refo[6]), .ref_range_select_o(refo[5]),
    .ref_supply_select_o(refo[4]), .ref_level_code_o(refo[3:0]),
    .current_range_o(crng), .current_trim_o(ctrim),
    .current_ground_o(gnd), .current_on_o(on),
    .cmp_two_b_route_o(route), .measure_pulse_o(mpo),
    .delay_pulse_out_o(dpo), .trigger_o(trg));
  edge_source_model u_edge_source_model (.ref_clk_i, .current_on_i(on),
    .current_ground_i(gnd), .line_o(line), .cmp_o(cmp));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic ln(input int i, input logic v);
    u_edge_source_model.set(i, v);
  endtask
  // waits an edge first so a release and a new setup never share a step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({a > 12'h00c, e});
    xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge ref_clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      ex = exp_q.pop_front();
      `CHK("read", ex, {pslverr_o, prdata_o})
    end
  end
  task automatic summarize();
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #50us;
    err_total++;
    summarize();
  end
  initial begin
    tick(2);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 12; a += 4) rd(12'(a), 32'h0);
    rd(12'h010, 32'h0);
    r = rnd();
    xfer(1'b1, 12'h000, r);
    rd(12'h000, r & 32'h00ff);
    `CHK("ref", r[7:0], refo)
    for (int c = 0; c < 4; c++) begin
      r = (rnd() & 32'h0000fc00) | (32'(c) << 8);
      xfer(1'b1, 12'h008, r);
      rd(12'h008, r);
      `CHK("current", r[15:8], {ctrim, crng})
    end
    xfer(1'b1, 12'h004, 32'hfffffffc);
    rd(12'h004, 32'hbffc);
    for (int k = 0; k < 16; k++) begin
      f = 32'h1 << k[3];
      cfg = 32'h8900 | ((k & 7) << (k[3] ? 5 : 2));
      cfg = cfg | (((k ^ 1) & 3) << (k[3] ? 2 : 5));
      xfer(1'b1, 12'h004, cfg);
      ln(k & 3, 1'b1);
      tick(3);
      rd(12'h004, cfg | (k[2] ? f : 32'h0));
      ln(k & 3, 1'b0);
      tick(3);
      rd(12'h004, cfg | f);
    end
    foreach (t[i]) begin
      xfer(1'b1, 12'h004, 32'(t[i][15:0]));
      idle_mode_i <= t[i][16];
      ln(3, 1'b1);
      tick(3);
      f = 32'(t[i][15] & t[i][11] & !(t[i][16] & t[i][13]));
      rd(12'h004, t[i][15:0] | f);
      ln(3, 1'b0);
      idle_mode_i <= 1'b0;
    end
    xfer(1'b1, 12'h004, 32'h8cdc);
    ln(2, 1'b1);
    tick(3);
    rd(12'h004, 32'h8cdc);
    ln(2, 1'b0);
    ln(3, 1'b1);
    tick(3);
    rd(12'h004, 32'h8cdd);
    `CHK("measure", 1'b1, mpo)
    ln(2, 1'b1);
    tick(3);
    rd(12'h004, 32'h8cdf);
    `CHK("measure", 1'b0, mpo)
    ln(2, 1'b0);
    ln(3, 1'b0);
    xfer(1'b1, 12'h008, 32'h0100);
    xfer(1'b1, 12'h004, 32'h0200);
    rd(12'h004, 32'h0200);
    `CHK("ground", 1'b1, gnd)
    `CHK("current on", 1'b0, on)
    xfer(1'b1, 12'h004, 32'h991c);
    rd(12'h00c, 32'h1);
    `CHK("route", 1'b1, route)
    ln(3, 1'b1);
    tick(2);
    rd(12'h00c, 32'h2);
    tick(30);
    rd(12'h00c, 32'h4);
    `CHK("delay pulse", 1'b1, dpo)
    `CHK("trigger", 1'b1, trg)
    xfer(1'b1, 12'h004, 32'h891c);
    rd(12'h00c, 32'h1);
    `CHK("route", 1'b0, route)
    `CHK("delay pulse", 1'b0, dpo)
    summarize();
  end
endmodule // charge_time_unit_tb
